// ---- logic/motor_mode_fault_supervisor.sv ----
// What this block does
// - open-loop angle is initial plus integrated frequency
// - open loop applies voltages, or current loop
// - current-loop enable changes only outside spin
// - voltage mode uses observer angle, voltage refs
// - current mode: d sets flux, q torque
// - speed mode holds d current at zero
// - speed mode feedback selectable; nonzero request starts
// - position P loop, stops at target
// - position mode needs encoder feedback
// - enabled fault moves drive to fault state
// - live fault bits follow conditions
// - overcurrent bit 0, kills pwm at once
// - undervoltage bit 1 below threshold
// - overvoltage bit 2 above threshold
// - overload flagged at bit 3
// - overspeed bit 4 above threshold
// - blocked rotor bit 5 after period
// - sticky latched flag per fault, vector too
// - latched faults clear on writing one
// - non-overcurrent faults have indication enables
// - overcurrent always active, never masked
// - drive switch enables and disables all pwm
module motor_mode_fault_supervisor (
  input  wire logic               clk,          // 250 mhz control clock
  input  wire logic               rst,          // sync reset, active high
  input  wire logic [11:0]        paddr,        // apb address
  input  wire logic               psel,         // apb select
  input  wire logic               penable,      // apb access phase
  input  wire logic               pwrite,       // apb direction
  input  wire logic [31:0]        pwdata,       // apb write data
  output logic                    pready,       // apb ready
  output logic      [31:0]        prdata,       // apb read data
  output logic                    pslverr,      // apb error
  input  wire logic [15:0]        bus_current,  // dc-bus current, unsigned
  input  wire logic [15:0]        bus_voltage,  // dc-bus voltage, unsigned
  input  wire logic [15:0]        rotor_speed,  // speed magnitude
  input  wire logic [15:0]        back_emf,     // back-emf magnitude
  input  wire logic               overload_in,  // rotor overload condition
  input  wire logic [15:0]        observer_angle, // sensorless angle
  input  wire logic [15:0]        encoder_angle,  // encoder angle
  input  wire logic signed [31:0] rotor_position, // encoder position count
  input  wire logic signed [15:0] meas_id,      // measured d current
  input  wire logic signed [15:0] meas_iq,      // measured q current
  output logic                    pwm_enable,   // inverter outputs on
  output logic      [15:0]        elec_angle,   // angle to modulator
  output logic signed [15:0]      vd_out,       // d voltage command
  output logic signed [15:0]      vq_out,       // q voltage command
  output logic signed [15:0]      id_cmd,       // d current reference
  output logic signed [15:0]      iq_cmd,       // q current reference
  output logic                    current_loop_on, // inner loop active
  output logic                    speed_loop_on,   // outer speed loop active
  output logic signed [15:0]      speed_cmd     // speed reference
);

  logic [31:0] ctrl_q, ctrl_d;
  logic [7:0]  fault_en_q;
  logic [7:0]  latched_q;
  logic [7:0]  live;
  logic [15:0] vd_ref_q, vq_ref_q, id_ref_q, iq_ref_q, freq_q, theta_init_q;
  logic [15:0] speed_req_q, uv_thr_q, ov_thr_q, oc_thr_q, os_thr_q;
  logic [15:0] blk_thr_q, blk_per_q, pos_kp_q;
  logic [31:0] pos_req_q;
  logic [15:0] blk_cnt_q;
  logic [15:0] angle_q;
  logic        olcur_q;
  logic        pos_done_q;
  logic        pwm_q;
  logic signed [15:0] vd_q, vq_q, idc_q, iqc_q, spd_q;
  motor_sup_pkg::drive_state_t state_q, state_d;

  // apb decode, zero wait states
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire wr_ctrl  = wr & (paddr == motor_sup_pkg::ctrl_off);
  wire wr_clr   = wr & (paddr == motor_sup_pkg::fault_clr_off);
  wire switch_on = ctrl_q[motor_sup_pkg::ctrl_switch_bit];
  wire enc_sel   = ctrl_q[motor_sup_pkg::ctrl_enc_bit];
  wire [2:0] mode_raw = ctrl_q[motor_sup_pkg::ctrl_mode_lsb +: 3];
  wire mode_pos  = (mode_raw == motor_sup_pkg::mode_position);
  wire mode_spd  = (mode_raw == motor_sup_pkg::mode_speed);
  wire mode_cur  = (mode_raw == motor_sup_pkg::mode_current);
  wire mode_vlt  = (mode_raw == motor_sup_pkg::mode_voltage);
  wire mode_ol   = (mode_raw == motor_sup_pkg::mode_open_loop);

  wire c_oc  = bus_current > oc_thr_q;
  wire c_uv  = bus_voltage < uv_thr_q;
  wire c_ov  = bus_voltage > ov_thr_q;
  wire c_os  = rotor_speed > os_thr_q;
  wire blk_low = back_emf < blk_thr_q;
  wire c_blk = blk_low & (blk_cnt_q > blk_per_q);
  wire [5:0] cond = {c_blk, c_os, overload_in, c_ov, c_uv, c_oc};

  // bits six and seven are zero
  assign live = {2'b00, cond & fault_en_q[5:0]} | {7'h00, c_oc};

  wire any_fault = |live;

  wire pos_ok = mode_pos & enc_sel;
  // speed mode runs only on nonzero request
  wire spd_go = mode_spd & (speed_req_q != 16'h0000);
  wire mode_ok = mode_ol | mode_vlt | mode_cur | spd_go | (pos_ok & ~pos_done_q);
  wire run_req = switch_on & mode_ok;

  wire signed [31:0] pos_err  = $signed(pos_req_q) - rotor_position;
  wire signed [47:0] pos_prod = pos_err * $signed(pos_kp_q);
  wire signed [15:0] pos_spd  = pos_prod[23:8];
  wire pos_in_win = (pos_err < $signed({16'h0000, motor_sup_pkg::pos_window}))
                  & (pos_err > -$signed({16'h0000, motor_sup_pkg::pos_window}));

  wire olcur_upd = wr_ctrl & (state_q != motor_sup_pkg::st_spin);
  always_comb begin
    ctrl_d = pwdata;
    ctrl_d[motor_sup_pkg::ctrl_olcur_bit] = olcur_upd ?
      pwdata[motor_sup_pkg::ctrl_olcur_bit] : olcur_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= motor_sup_pkg::ctrl_rst;
      olcur_q <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_d;
      olcur_q <= ctrl_d[motor_sup_pkg::ctrl_olcur_bit];
    end
  end

  // plain setting registers
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_en_q   <= motor_sup_pkg::fault_en_rst;
      vd_ref_q     <= 16'h0000;
      vq_ref_q     <= 16'h0000;
      id_ref_q     <= 16'h0000;
      iq_ref_q     <= 16'h0000;
      freq_q       <= 16'h0000;
      theta_init_q <= 16'h0000;
      speed_req_q  <= 16'h0000;
      pos_req_q    <= 32'h0000_0000;
      uv_thr_q     <= motor_sup_pkg::uv_thr_rst;
      ov_thr_q     <= motor_sup_pkg::ov_thr_rst;
      oc_thr_q     <= motor_sup_pkg::oc_thr_rst;
      os_thr_q     <= motor_sup_pkg::os_thr_rst;
      blk_thr_q    <= motor_sup_pkg::blk_thr_rst;
      blk_per_q    <= motor_sup_pkg::blk_per_rst;
      pos_kp_q     <= motor_sup_pkg::pos_kp_rst;
    end else if (wr) begin
      case (paddr)
        motor_sup_pkg::fault_en_off:   fault_en_q   <= pwdata[7:0] & 8'h3e;
        motor_sup_pkg::vd_ref_off:     vd_ref_q     <= pwdata[15:0];
        motor_sup_pkg::vq_ref_off:     vq_ref_q     <= pwdata[15:0];
        motor_sup_pkg::id_ref_off:     id_ref_q     <= pwdata[15:0];
        motor_sup_pkg::iq_ref_off:     iq_ref_q     <= pwdata[15:0];
        motor_sup_pkg::freq_off:       freq_q       <= pwdata[15:0];
        motor_sup_pkg::theta_init_off: theta_init_q <= pwdata[15:0];
        motor_sup_pkg::speed_req_off:  speed_req_q  <= pwdata[15:0];
        motor_sup_pkg::pos_req_off:    pos_req_q    <= pwdata;
        motor_sup_pkg::uv_thr_off:     uv_thr_q     <= pwdata[15:0];
        motor_sup_pkg::ov_thr_off:     ov_thr_q     <= pwdata[15:0];
        motor_sup_pkg::oc_thr_off:     oc_thr_q     <= pwdata[15:0];
        motor_sup_pkg::os_thr_off:     os_thr_q     <= pwdata[15:0];
        motor_sup_pkg::blk_thr_off:    blk_thr_q    <= pwdata[15:0];
        motor_sup_pkg::blk_per_off:    blk_per_q    <= pwdata[15:0];
        motor_sup_pkg::pos_kp_off:     pos_kp_q     <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // clear copies live, so an event in the clear cycle survives
  // sticky capture, set beats clear
  // cleared by writing one to bit 0
  always_ff @(posedge clk) begin
    if (rst) begin
      latched_q <= 8'h00;
    end else if (wr_clr & pwdata[0]) begin
      latched_q <= live;
    end else begin
      latched_q <= latched_q | live;
    end
  end

  // saturates so a long stall never wraps back to zero
  // saturating low back-emf timer
  always_ff @(posedge clk) begin
    if (rst || !blk_low) begin
      blk_cnt_q <= 16'h0000;
    end else if (blk_cnt_q != 16'hffff) begin
      blk_cnt_q <= blk_cnt_q + 16'h0001;
    end
  end

  always_comb begin
    case (state_q)
      motor_sup_pkg::st_stop:  state_d = any_fault ? motor_sup_pkg::st_fault :
                                         run_req ? motor_sup_pkg::st_spin :
                                         motor_sup_pkg::st_stop;
      motor_sup_pkg::st_spin:  state_d = any_fault ? motor_sup_pkg::st_fault :
                                         run_req ? motor_sup_pkg::st_spin :
                                         motor_sup_pkg::st_stop;
      // leave fault only once conditions gone and switch off
      motor_sup_pkg::st_fault: state_d = (any_fault || switch_on) ?
                                         motor_sup_pkg::st_fault : motor_sup_pkg::st_stop;
      default:                 state_d = motor_sup_pkg::st_stop;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= motor_sup_pkg::st_stop;
    end else begin
      state_q <= state_d;
    end
  end

  // stop at target; rearmed by switching off
  always_ff @(posedge clk) begin
    if (rst || !switch_on) begin
      pos_done_q <= 1'b0;
    end else if (pos_ok && state_q == motor_sup_pkg::st_spin && pos_in_win) begin
      pos_done_q <= 1'b1;
    end
  end

  // angle integrator, freq in angle units per cycle
  always_ff @(posedge clk) begin
    if (rst || state_q != motor_sup_pkg::st_spin) begin
      angle_q <= theta_init_q;
    end else begin
      angle_q <= angle_q + freq_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= switch_on & (state_d == motor_sup_pkg::st_spin);
    end
  end
  assign pwm_enable = pwm_q & ~c_oc;

  // current loops act on the reference error
  // proportional only: the gain is a fixed shift, no integrator
  wire signed [15:0] id_tgt = (mode_spd | mode_pos) ? 16'sh0000 : $signed(id_ref_q);
  wire signed [15:0] iq_tgt = (mode_spd | mode_pos) ? 16'sh0000 : $signed(iq_ref_q);
  wire signed [16:0] id_err = 17'(id_tgt) - 17'(meas_id);
  wire signed [16:0] iq_err = 17'(iq_tgt) - 17'(meas_iq);
  wire signed [16:0] id_corr = id_err >>> motor_sup_pkg::curr_kp_shift;
  wire signed [16:0] iq_corr = iq_err >>> motor_sup_pkg::curr_kp_shift;
  wire volt_direct = (mode_ol & ~olcur_q) | mode_vlt;
  // voltage mode always on the observer angle
  wire [15:0] fb_angle = (mode_vlt | ~enc_sel) ? observer_angle : encoder_angle;

  // reference routing per mode
  wire spin = (state_q == motor_sup_pkg::st_spin);
  always_ff @(posedge clk) begin
    if (rst || !spin) begin
      vd_q <= 16'sh0000;
      vq_q <= 16'sh0000;
      idc_q <= 16'sh0000;
      iqc_q <= 16'sh0000;
      spd_q <= 16'sh0000;
      current_loop_on <= 1'b0;
      speed_loop_on <= 1'b0;
      elec_angle <= 16'h0000;
    end else begin
      elec_angle <= mode_ol ? angle_q : fb_angle;
      // voltages, or currents when loop enabled
      vd_q <= volt_direct ? $signed(vd_ref_q) : $signed(id_corr[15:0]);
      vq_q <= volt_direct ? $signed(vq_ref_q) : $signed(iq_corr[15:0]);
      current_loop_on <= (mode_ol & olcur_q) | mode_cur | mode_spd | mode_pos;
      speed_loop_on <= mode_spd | mode_pos;
      // d ref flux, signed q ref torque
      // d current zero in speed loops
      idc_q <= id_tgt;
      iqc_q <= iq_tgt;
      spd_q <= mode_pos ? pos_spd : $signed(speed_req_q);
    end
  end
  assign vd_out = vd_q;
  assign vq_out = vq_q;
  assign id_cmd = idc_q;
  assign iq_cmd = iqc_q;
  assign speed_cmd = spd_q;

  // read mux
  always_comb begin
    case (paddr)
      motor_sup_pkg::ctrl_off:       prdata = ctrl_q;
      motor_sup_pkg::fault_en_off:   prdata = {24'h0, fault_en_q | 8'h01};
      motor_sup_pkg::fault_clr_off:  prdata = 32'h0;
      motor_sup_pkg::live_off:       prdata = {24'h0, live};
      motor_sup_pkg::latched_off:    prdata = {24'h0, latched_q};
      motor_sup_pkg::vd_ref_off:     prdata = {16'h0, vd_ref_q};
      motor_sup_pkg::vq_ref_off:     prdata = {16'h0, vq_ref_q};
      motor_sup_pkg::id_ref_off:     prdata = {16'h0, id_ref_q};
      motor_sup_pkg::iq_ref_off:     prdata = {16'h0, iq_ref_q};
      motor_sup_pkg::freq_off:       prdata = {16'h0, freq_q};
      motor_sup_pkg::theta_init_off: prdata = {16'h0, theta_init_q};
      motor_sup_pkg::speed_req_off:  prdata = {16'h0, speed_req_q};
      motor_sup_pkg::pos_req_off:    prdata = pos_req_q;
      motor_sup_pkg::uv_thr_off:     prdata = {16'h0, uv_thr_q};
      motor_sup_pkg::ov_thr_off:     prdata = {16'h0, ov_thr_q};
      motor_sup_pkg::oc_thr_off:     prdata = {16'h0, oc_thr_q};
      motor_sup_pkg::os_thr_off:     prdata = {16'h0, os_thr_q};
      motor_sup_pkg::blk_thr_off:    prdata = {16'h0, blk_thr_q};
      motor_sup_pkg::blk_per_off:    prdata = {16'h0, blk_per_q};
      motor_sup_pkg::pos_kp_off:     prdata = {16'h0, pos_kp_q};
      motor_sup_pkg::state_off:      prdata = {28'h0, state_q};
      motor_sup_pkg::angle_off:      prdata = {16'h0, angle_q};
      default:                       prdata = 32'h0;
    endcase
  end
  // every register answers at once, no wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;

endmodule : motor_mode_fault_supervisor

// ---- logic/motor_sup_pkg.sv ----
package motor_sup_pkg;

  // register byte addresses
  localparam logic [11:0] ctrl_off       = 12'h000;
  localparam logic [11:0] fault_en_off   = 12'h004;
  localparam logic [11:0] fault_clr_off  = 12'h008;
  localparam logic [11:0] live_off       = 12'h00c;
  localparam logic [11:0] latched_off    = 12'h010;
  localparam logic [11:0] vd_ref_off     = 12'h014;
  localparam logic [11:0] vq_ref_off     = 12'h018;
  localparam logic [11:0] id_ref_off     = 12'h01c;
  localparam logic [11:0] iq_ref_off     = 12'h020;
  localparam logic [11:0] freq_off       = 12'h024;
  localparam logic [11:0] theta_init_off = 12'h028;
  localparam logic [11:0] speed_req_off  = 12'h02c;
  localparam logic [11:0] pos_req_off    = 12'h030;
  localparam logic [11:0] uv_thr_off     = 12'h034;
  localparam logic [11:0] ov_thr_off     = 12'h038;
  localparam logic [11:0] oc_thr_off     = 12'h03c;
  localparam logic [11:0] os_thr_off     = 12'h040;
  localparam logic [11:0] blk_thr_off    = 12'h044;
  localparam logic [11:0] blk_per_off    = 12'h048;
  localparam logic [11:0] pos_kp_off     = 12'h04c;
  localparam logic [11:0] state_off      = 12'h050;
  localparam logic [11:0] angle_off      = 12'h054;

  // control register fields
  localparam int ctrl_switch_bit = 0;
  localparam int ctrl_olcur_bit  = 1;
  localparam int ctrl_enc_bit    = 2;
  localparam int ctrl_mode_lsb   = 4;

  // fault bit positions
  localparam int f_oc  = 0;
  localparam int f_uv  = 1;
  localparam int f_ov  = 2;
  localparam int f_ol  = 3;
  localparam int f_os  = 4;
  localparam int f_blk = 5;

  localparam logic [7:0]  fault_en_rst  = 8'h3e;
  localparam logic [7:0]  fault_used    = 8'h3f;
  localparam logic [31:0] ctrl_rst      = 32'h0000_0000;
  localparam logic [15:0] blk_per_rst   = 16'h03e8;
  localparam logic [15:0] pos_kp_rst    = 16'h0100;
  localparam logic [15:0] oc_thr_rst    = 16'h7fff;
  localparam logic [15:0] ov_thr_rst    = 16'h7fff;
  localparam logic [15:0] os_thr_rst    = 16'h7fff;
  localparam logic [15:0] uv_thr_rst    = 16'h0000;
  localparam logic [15:0] blk_thr_rst   = 16'h0000;
  localparam logic [15:0] pos_window    = 16'h0010;
  localparam logic [15:0] curr_kp_shift = 16'h0004;

  typedef enum logic [2:0] {
    mode_open_loop = 3'h0,
    mode_voltage   = 3'h1,
    mode_current   = 3'h2,
    mode_speed     = 3'h3,
    mode_position  = 3'h4
  } ctrl_mode_t;

  typedef enum logic [3:0] {
    st_stop  = 4'b0001,
    st_spin  = 4'b0010,
    st_fault = 4'b0100,
    st_idle  = 4'b1000
  } drive_state_t;

endpackage : motor_sup_pkg

// ---- verif/motor_sup_asserts.sv ----
module motor_sup_asserts (
  input wire logic               clk,             // clock
  input wire logic               rst,             // sync reset
  input wire logic [11:0]        paddr,           // apb address
  input wire logic               psel,            // apb select
  input wire logic               penable,         // apb access
  input wire logic               pwrite,          // apb direction
  input wire logic [31:0]        pwdata,          // apb write data
  input wire logic               pready,          // apb ready
  input wire logic [31:0]        prdata,          // apb read data
  input wire logic               pslverr,         // apb error
  input wire logic [15:0]        bus_current,     // bus current
  input wire logic               pwm_enable,      // inverter on
  input wire logic signed [15:0] vd_out,          // d voltage
  input wire logic signed [15:0] vq_out,          // q voltage
  input wire logic signed [15:0] id_cmd,          // d current ref
  input wire logic               current_loop_on, // inner loop
  input wire logic               speed_loop_on    // speed loop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic acc     = psel && penable && !pwrite;
  wire logic rd_live = acc && paddr == motor_sup_pkg::live_off;
  wire logic rd_vec  = rd_live || (acc && paddr == motor_sup_pkg::latched_off);
  wire logic sw_off  = psel && penable && pwrite && paddr == motor_sup_pkg::ctrl_off && !pwdata[0];
  // the bench never moves the overcurrent threshold off its reset value
  wire logic oc      = bus_current > motor_sup_pkg::oc_thr_rst;

  a_apb_no_wait: assert property (psel |-> pready && !pslverr)
    else $error("apb slave stalled or flagged an error");
  a_oc_pwm_off: assert property (oc |-> !pwm_enable)
    else $error("pwm still on during overcurrent");
  a_oc_always_live: assert property (rd_live && oc |-> prdata[0])
    else $error("overcurrent missing from live vector");
  a_vec_top_zero: assert property (rd_vec |-> prdata[31:6] == '0)
    else $error("fault vector upper bits set");
  a_switch_off_pwm: assert property (sw_off |-> ##[1:3] !pwm_enable)
    else $error("pwm still on after switch off");
  a_idle_outputs: assert property (!pwm_enable [*4] |-> vd_out == 0 && vq_out == 0
    && !current_loop_on && !speed_loop_on)
    else $error("commands active while inverter off");
  a_speed_d_zero: assert property (speed_loop_on |-> id_cmd == 0)
    else $error("d current nonzero in speed loop");
  a_fault_pwm_off: assert property (rd_live && prdata[5:0] != 0 |=> !pwm_enable)
    else $error("pwm on after enabled fault");
  c_switch_off: cover property (sw_off);
  c_speed_loop: cover property (speed_loop_on);
  c_overcurrent: cover property (oc);
  c_current_loop: cover property (current_loop_on);
endmodule : motor_sup_asserts

// ---- verif/inverter_model.sv ----
module inverter_model (
  input wire logic               clk,            // clock
  input wire logic               rst,            // sync reset
  input wire logic               pwm_enable,     // bridge enabled
  input wire logic signed [15:0] vd_out,         // d voltage
  input wire logic signed [15:0] vq_out,         // q voltage
  input wire logic signed [15:0] speed_cmd,      // speed reference
  output logic [15:0]            observer_angle, // estimated angle
  output logic [15:0]            encoder_angle,  // encoder angle
  output logic signed [31:0]     rotor_position, // encoder count
  output logic signed [15:0]     meas_id,        // d current
  output logic signed [15:0]     meas_iq         // q current
);
  timeunit 1ns;
  timeprecision 1ps;
  // current only flows while the bridge switches
  assign meas_id       = pwm_enable ? vd_out : 16'sh0000;
  assign meas_iq       = pwm_enable ? vq_out : 16'sh0000;
  assign encoder_angle = rotor_position[15:0] << 6;
  always_ff @(posedge clk) begin
    if (rst) begin
      observer_angle <= 16'h0000;
      rotor_position <= 32'sh0000_0000;
    end else begin
      observer_angle <= observer_angle + 16'h0007;
      // shaft moves one count a cycle toward the speed reference
      if (pwm_enable && speed_cmd > 0) rotor_position <= rotor_position + 1;
      else if (pwm_enable && speed_cmd < 0) rotor_position <= rotor_position - 1;
    end
  end
endmodule : inverter_model

// ---- verif/motor_mode_fault_supervisor_tb.sv ----
module motor_mode_fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
  logic clk, rst, psel, penable, pwrite, pready, pslverr, overload_in;
  logic pwm_enable, current_loop_on, speed_loop_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] bus_current, bus_voltage, rotor_speed, back_emf;
  logic [15:0] observer_angle, encoder_angle, elec_angle, a1;
  logic signed [31:0] rotor_position;
  logic signed [15:0] meas_id, meas_iq, vd_out, vq_out, id_cmd, iq_cmd, speed_cmd;
  int err_count, compares, cyc;

  motor_mode_fault_supervisor motor_mode_fault_supervisor_inst (.clk, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr, .bus_current, .bus_voltage,
    .rotor_speed, .back_emf, .overload_in, .observer_angle, .encoder_angle, .rotor_position,
    .meas_id, .meas_iq, .pwm_enable, .elec_angle, .vd_out, .vq_out, .id_cmd, .iq_cmd,
    .current_loop_on, .speed_loop_on, .speed_cmd);
  inverter_model inverter_model_inst (.clk, .rst, .pwm_enable, .vd_out, .vq_out, .speed_cmd,
    .observer_angle, .encoder_angle, .rotor_position, .meas_id, .meas_iq);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task print_verdict;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, r);
    `CK($sformatf("register %h", a), e, r)
  endtask : rc

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic set_fault(input int f, input logic on);
    case (f)
      0: bus_current <= on ? 16'h8000 : 16'h0100;
      1: bus_voltage <= on ? 16'h0080 : 16'h4000;
      2: bus_voltage <= on ? 16'h8000 : 16'h4000;
      3: overload_in <= on;
      4: rotor_speed <= on ? 16'h8000 : 16'h0100;
      default: back_emf <= on ? 16'h0000 : 16'h4000;
    endcase
  endtask : set_fault

  task automatic t_reset;
    rc(motor_sup_pkg::fault_en_off, 32'h0000_003f);
    rc(motor_sup_pkg::blk_per_off, 32'h0000_03e8);
    rc(motor_sup_pkg::oc_thr_off, 32'h0000_7fff);
    rc(motor_sup_pkg::uv_thr_off, 32'h0000_0000);
    rc(motor_sup_pkg::state_off, 32'h0000_0001);
    rc(12'h0fc, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_open;
    wr(motor_sup_pkg::vd_ref_off, 32'h0000_0100);
    wr(motor_sup_pkg::vq_ref_off, 32'h0000_0200);
    wr(motor_sup_pkg::id_ref_off, 32'h0000_0050);
    wr(motor_sup_pkg::freq_off, 32'h0000_0010);
    wr(motor_sup_pkg::theta_init_off, 32'h0000_1000);
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0001);
    tick(3);
    `CK("pwm_enable", 1'b1, pwm_enable)
    `CK("vd_out", 16'h0100, vd_out)
    `CK("vq_out", 16'h0200, vq_out)
    a1 = elec_angle;
    tick(10);
    `CK("angle step", 16'h00a0, 16'(elec_angle - a1))
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0003);
    rc(motor_sup_pkg::ctrl_off, 32'h0000_0001);
    `CK("current_loop_on", 1'b0, current_loop_on)
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0000);
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0002);
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0003);
    tick(3);
    `CK("current_loop_on", 1'b1, current_loop_on)
    `CK("id_cmd", 16'h0050, id_cmd)
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0000);
    $display("test open loop done");
  endtask : t_open

  task automatic t_modes;
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0011);
    tick(3);
    `CK("vq_out", 16'h0200, vq_out)
    `CK("current_loop_on", 1'b0, current_loop_on)
    wr(motor_sup_pkg::iq_ref_off, 32'h0000_0060);
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0021);
    tick(3);
    `CK("iq_cmd", 16'h0060, iq_cmd)
    `CK("id_cmd", 16'h0050, id_cmd)
    wr(motor_sup_pkg::iq_ref_off, 32'h0000_ffa0);
    tick(3);
    `CK("iq_cmd", 16'hffa0, iq_cmd)
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0000);
    $display("test voltage and current done");
  endtask : t_modes

  task automatic t_speed_pos;
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0031);
    tick(4);
    rc(motor_sup_pkg::state_off, 32'h0000_0001);
    wr(motor_sup_pkg::speed_req_off, 32'h0000_0200);
    tick(4);
    rc(motor_sup_pkg::state_off, 32'h0000_0002);
    `CK("speed_loop_on", 1'b1, speed_loop_on)
    `CK("id_cmd", 16'h0000, id_cmd)
    `CK("speed_cmd", 16'h0200, speed_cmd)
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0000);
    wr(motor_sup_pkg::pos_req_off, 32'h0000_0064);
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0041);
    tick(4);
    rc(motor_sup_pkg::state_off, 32'h0000_0001);
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0045);
    tick(3);
    rc(motor_sup_pkg::state_off, 32'h0000_0002);
    for (int i = 0; i < 300 && r !== 32'h0000_0001; i++) apb(1'b0, motor_sup_pkg::state_off, 0, r);
    `CK("stop state", 32'h0000_0001, r)
    `CK("at target", 1'b1, rotor_position > 84 && rotor_position < 116)
    wr(motor_sup_pkg::ctrl_off, 32'h0000_0000);
    $display("test speed and position done");
  endtask : t_speed_pos

  task automatic t_faults;
    wr(motor_sup_pkg::uv_thr_off, 32'h0000_0100);
    wr(motor_sup_pkg::blk_thr_off, 32'h0000_0100);
    wr(motor_sup_pkg::blk_per_off, 32'h0000_0004);
    for (int f = 0; f < 6; f++) begin
      wr(motor_sup_pkg::ctrl_off, 32'h0000_0001);
      set_fault(f, 1'b1);
      tick(8);
      rc(motor_sup_pkg::live_off, 32'h1 << f);
      rc(motor_sup_pkg::state_off, 32'h0000_0004);
      `CK("pwm_enable", 1'b0, pwm_enable)
      set_fault(f, 1'b0);
      tick(2);
      rc(motor_sup_pkg::live_off, 32'h0000_0000);
      wr(motor_sup_pkg::fault_clr_off, 32'h0000_0000);
      rc(motor_sup_pkg::latched_off, 32'h1 << f);
      wr(motor_sup_pkg::ctrl_off, 32'h0000_0000);
      wr(motor_sup_pkg::fault_clr_off, 32'h0000_0001);
      rc(motor_sup_pkg::latched_off, 32'h0000_0000);
      rc(motor_sup_pkg::state_off, 32'h0000_0001);
    end
    wr(motor_sup_pkg::fault_en_off, 32'h0000_0000);
    rc(motor_sup_pkg::fault_en_off, 32'h0000_0001);
    set_fault(0, 1'b1);
    set_fault(1, 1'b1);
    tick(4);
    rc(motor_sup_pkg::live_off, 32'h0000_0001);
    rc(motor_sup_pkg::latched_off, 32'h0000_0001);
    set_fault(0, 1'b0);
    set_fault(1, 1'b0);
    wr(motor_sup_pkg::fault_clr_off, 32'h0000_0001);
    wr(motor_sup_pkg::fault_en_off, 32'h0000_003e);
    $display("test faults done");
  endtask : t_faults

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, overload_in} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    bus_current = 16'h0100;
    bus_voltage = 16'h4000;
    rotor_speed = 16'h0100;
    back_emf = 16'h4000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_open();
    t_modes();
    t_speed_pos();
    t_faults();
    print_verdict();
  end
endmodule : motor_mode_fault_supervisor_tb

bind motor_mode_fault_supervisor motor_sup_asserts motor_sup_asserts_inst (.clk, .rst, .paddr,
  .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr, .bus_current, .pwm_enable,
  .vd_out, .vq_out, .id_cmd, .current_loop_on, .speed_loop_on);
